/* File: rtl/ddrlc_capture.sv */
/*
 Input capture of the 16-bit double-data-rate sample bus: clock, marker
 and data pins are oversampled on sys_clk, one word is taken per link
 clock edge and queued in a two-entry buffer; marker samples give frame
 start, pointer reset or sync, and an optional parity check of falling-edge words.
 Assumes the link clock half period is well above the capture delay plus
 the synchroniser latency, and that sink stalls stay short.
 Latency from a link clock edge to word_valid is about nine cycles:
 two synchroniser stages, edge detect, settling countdown, capture and
 the buffer register. Edges that arrive while a capture is pending are
 not seen, so each link half period must exceed CAPTURE_DLY plus one
 cycle. The reference pin output means something only while its
 active-low enable is low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ddrlc_regs.svh"

module ddrlc_capture
   import ddrlc_pkg::*;
#(
   parameter int CAPTURE_DLY = `DDRLC_CAPTURE_DLY
) (
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire logic                     forwarded_sample_clock,
   input  wire logic                     frame_marker_line,
   input  wire logic [`DDRLC_DATA_W-1:0] sample_data_line,
   input  wire logic                     frame_mode_sync,
   input  wire logic                     parity_check_en,
   input  wire logic [`DDRLC_CFG_W-1:0]  reference_config_word,
   input  wire logic                     reference_io_pin_in,
   output logic                          reference_io_pin_out,
   output logic                          reference_io_pin_oe_n,
   output logic                          internal_ref_enable,
   output logic                          external_ref_sense,
   output logic                          word_valid,
   input  wire logic                     word_ready,
   output ddrlc_word_t                   word_out,
   output logic                          fifo_ptr_reset,
   output logic                          sync_event,
   output logic                          frame_start,
   output logic                          parity_error,
   output logic                          capture_overflow
);

   ddrlc_cap_state_t s_q;
   ddrlc_cap_state_t s_d;
   ddrlc_lane_t      lane_pins;
   logic             buf_ready;
   logic             rise_seen;
   logic             fall_seen;
   logic             rise_word;
   logic             fall_word;

   // Reset image; the reference pin comes up driving the internal level
   localparam logic [`DDRLC_CFG_W-1:0] CFG_RST     = `DDRLC_CFG_RESET;
   localparam logic                    REF_INT_RST = !CFG_RST[`DDRLC_CFG_EXTREF];

   // Link idles low, so a zero clock history gives no false edge at release
   localparam ddrlc_cap_state_t CAP_RST = '{
      lane_s1:         '0,
      lane_s2:         '0,
      clk_prev:        1'b0,
      phase:           DDRLC_IDLE,
      dly_cnt:         '0,
      word:            '0,
      push:            1'b0,
      rise_frame_prev: 1'b0,
      ptr_reset:       1'b0,
      sync_event:      1'b0,
      frame_start:     1'b0,
      parity_err:      1'b0,
      overflow:        1'b0,
      ref_int_en:      REF_INT_RST,
      ref_s1:          1'b0,
      ref_s2:          1'b0
   };

   // Even parity of a word against its marker bit
   function automatic logic parity_bad(input ddrlc_word_t w);
      parity_bad = (^w.data) != w.frame_bit;
   endfunction

   // Edge of the synced link clock against its one-cycle history
   function automatic logic link_edge(input logic now, input logic prev, input logic rising);
      link_edge = rising ? (now && !prev) : (!now && prev);
   endfunction

   // Countdown load for either edge, one place to retune settling
   function automatic logic [`DDRLC_DLY_W-1:0] dly_load();
      dly_load = `DDRLC_DLY_W'(CAPTURE_DLY);
   endfunction

   // Frame start: rising-word marker set after a clear one
   function automatic logic marker_rise(input ddrlc_word_t w, input logic prev);
      marker_rise = w.frame_bit && !prev;
   endfunction

   // Pin group, synchronised as one
   assign lane_pins.clk   = forwarded_sample_clock;
   assign lane_pins.frame = frame_marker_line;
   assign lane_pins.data  = sample_data_line;

   // Edges seen on the second synchroniser stage only
   assign rise_seen = link_edge(s_q.lane_s2.clk, s_q.clk_prev, 1'b1);
   assign fall_seen = link_edge(s_q.lane_s2.clk, s_q.clk_prev, 1'b0);

   // Word just taken, split by the edge that carried it
   assign rise_word = s_q.push && !s_q.word.fall_edge;
   assign fall_word = s_q.push && s_q.word.fall_edge;

   // Next-state logic
   always_comb begin
      s_d = s_q;
      // Event pulses default low every cycle
      s_d.push        = 1'b0;
      s_d.ptr_reset   = 1'b0;
      s_d.sync_event  = 1'b0;
      s_d.frame_start = 1'b0;
      s_d.parity_err  = 1'b0;
      s_d.overflow    = 1'b0;

      // Two-stage synchronisers; stage one feeds stage two only
      s_d.lane_s1  = lane_pins;
      s_d.lane_s2  = s_q.lane_s1;
      s_d.clk_prev = s_q.lane_s2.clk;

      // Reference pin sense, same two-flop treatment
      s_d.ref_s1   = reference_io_pin_in;
      s_d.ref_s2   = s_q.ref_s1;

      // Set selects external reference, clear keeps internal drive
      s_d.ref_int_en = !reference_config_word[`DDRLC_CFG_EXTREF];

      // Edge-aligned source: wait a few cycles so the new word is settled
      case (s_q.phase)
         DDRLC_IDLE: begin
            // Rise and fall cannot both show in one cycle
            if (rise_seen) begin
               s_d.phase   = DDRLC_WAIT_RISE;
               s_d.dly_cnt = dly_load();
            end else if (fall_seen) begin
               s_d.phase   = DDRLC_WAIT_FALL;
               s_d.dly_cnt = dly_load();
            end
         end
         DDRLC_WAIT_RISE,
         DDRLC_WAIT_FALL: begin
            // Edges met here are lost; half period must cover the wait
            if (s_q.dly_cnt != '0) begin
               s_d.dly_cnt = s_q.dly_cnt - `DDRLC_DLY_W'(1);
            end else begin
               // One word per edge, marker of the same edge attached
               s_d.word.data      = s_q.lane_s2.data;
               s_d.word.frame_bit = s_q.lane_s2.frame;
               s_d.word.fall_edge = (s_q.phase == DDRLC_WAIT_FALL);
               s_d.push           = 1'b1;
               s_d.phase          = DDRLC_IDLE;
            end
         end
         default: begin
            s_d.phase = DDRLC_IDLE;
         end
      endcase

      // Rising-edge word: frame start and its routing, one cycle on
      if (rise_word) begin
         s_d.rise_frame_prev = s_q.word.frame_bit;
         if (marker_rise(s_q.word, s_q.rise_frame_prev)) begin
            s_d.frame_start = 1'b1;
            s_d.sync_event  = frame_mode_sync;
            s_d.ptr_reset   = !frame_mode_sync;
         end
      end

      // Falling-edge word: optional parity check
      if (fall_word && parity_check_en) begin
         s_d.parity_err = parity_bad(s_q.word);
      end

      // A word the full buffer cannot take is reported, not hidden
      if (s_q.push && !buf_ready) begin
         s_d.overflow = 1'b1;
      end
   end

   // State register; constants only under reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= CAP_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Two-entry buffer absorbs short sink stalls
   ddrlc_buf2 #(
      .WIDTH ($bits(ddrlc_word_t)),
      .DEPTH (`DDRLC_BUF_DEPTH)
   ) u_buf (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_valid  (s_q.push),
      .in_ready  (buf_ready),
      .in_data   (s_q.word),
      .out_valid (word_valid),
      .out_ready (word_ready),
      .out_data  (word_out)
   );

   // Reference pin drives only while internal reference is on
   assign reference_io_pin_out  = s_q.ref_int_en;
   assign reference_io_pin_oe_n = !s_q.ref_int_en;

   // Reference status for whoever watches the converter core
   assign internal_ref_enable   = s_q.ref_int_en;
   assign external_ref_sense    = s_q.ref_s2;

   // One-cycle event pulses, all straight from flops
   assign fifo_ptr_reset        = s_q.ptr_reset;
   assign sync_event            = s_q.sync_event;
   assign frame_start           = s_q.frame_start;
   assign parity_error          = s_q.parity_err;
   assign capture_overflow      = s_q.overflow;
endmodule // ddrlc_capture
`default_nettype wire

/* File: rtl/ddrlc_regs.svh */
/*
 Named constants of the double-data-rate input capture front end.
 Assumes inclusion by bare name from package and modules alike.
*/
// Overview of operation
// - Both edges of the forwarded sample clock each take one 16-bit word from the data lines.
// - The frame marker taken with a rising edge resets the FIFO pointer or serves as a sync source.
// - The frame marker taken with a falling edge may be checked as a parity bit for its word.
// - The host raises the frame marker on a frame's first word, and that word marks frame start.
// - Reference select bit set means external reference in, clear (default) means internal out.
`ifndef DDRLC_REGS_SVH
`define DDRLC_REGS_SVH

`define DDRLC_DATA_W        16
`define DDRLC_CFG_W         16
`define DDRLC_CFG_EXTREF    0
`define DDRLC_CFG_RESET     16'h0000
`define DDRLC_CAPTURE_DLY   4
`define DDRLC_DLY_W         4
`define DDRLC_BUF_DEPTH     2

`endif

/* File: rtl/ddrlc_pkg.sv */
/*
 Types of the double-data-rate input capture front end.
 Assumes the constants header sits beside it.
*/
`include "ddrlc_regs.svh"

package ddrlc_pkg;

   // Raw pin group, sampled together
   typedef struct packed {
      logic                      clk;
      logic                      frame;
      logic [`DDRLC_DATA_W-1:0]  data;
   } ddrlc_lane_t;

   // One captured word with its marker sample
   typedef struct packed {
      logic [`DDRLC_DATA_W-1:0]  data;
      logic                      fall_edge;
      logic                      frame_bit;
   } ddrlc_word_t;

   // Capture sequencer states
   typedef enum logic [1:0] {
      DDRLC_IDLE      = 2'b00,
      DDRLC_WAIT_RISE = 2'b01,
      DDRLC_WAIT_FALL = 2'b10
   } ddrlc_phase_t;

   // Full state of the capture module
   typedef struct packed {
      ddrlc_lane_t               lane_s1;
      ddrlc_lane_t               lane_s2;
      logic                      clk_prev;
      ddrlc_phase_t              phase;
      logic [`DDRLC_DLY_W-1:0]   dly_cnt;
      ddrlc_word_t               word;
      logic                      push;
      logic                      rise_frame_prev;
      logic                      ptr_reset;
      logic                      sync_event;
      logic                      frame_start;
      logic                      parity_err;
      logic                      overflow;
      logic                      ref_int_en;
      logic                      ref_s1;
      logic                      ref_s2;
   } ddrlc_cap_state_t;

endpackage

/* File: rtl/ddrlc_buf2.sv */
/*
 Small valid/ready buffer, two entries by default.
 Assumes source and sink on sys_clk; in_ready drops only when full.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ddrlc_regs.svh"

module ddrlc_buf2 #(
   parameter int WIDTH = 18,
   parameter int DEPTH = `DDRLC_BUF_DEPTH
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr_ptr;
      logic [PW-1:0]               rd_ptr;
      logic [PW:0]                 count;
   } ddrlc_buf_state_t;

   ddrlc_buf_state_t s_q;
   ddrlc_buf_state_t s_d;
   logic             do_wr;
   logic             do_rd;

   // Honest full and empty straight from the count
   assign in_ready  = (s_q.count != (PW+1)'(DEPTH));
   assign out_valid = (s_q.count != '0);
   assign out_data  = s_q.mem[s_q.rd_ptr];
   assign do_wr     = in_valid && in_ready;
   assign do_rd     = out_valid && out_ready;

   // Pointer wrap works for any depth, not only powers of two
   always_comb begin
      s_d = s_q;
      if (do_wr) begin
         s_d.mem[s_q.wr_ptr] = in_data;
         s_d.wr_ptr = (s_q.wr_ptr == PW'(DEPTH-1)) ? '0 : s_q.wr_ptr + PW'(1);
      end
      if (do_rd) begin
         s_d.rd_ptr = (s_q.rd_ptr == PW'(DEPTH-1)) ? '0 : s_q.rd_ptr + PW'(1);
      end
      if (do_wr && !do_rd) begin
         s_d.count = s_q.count + (PW+1)'(1);
      end else if (do_rd && !do_wr) begin
         s_d.count = s_q.count - (PW+1)'(1);
      end
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule // ddrlc_buf2
`default_nettype wire

/* File: tb/ddrlc_capture_assertions.sv */
/* Port checker of the capture front end.
   Assumes it is bound onto ddrlc_capture. */
`timescale 1ns/1ps
`default_nettype none
module ddrlc_chk
   import ddrlc_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        internal_ref_enable,
   input wire logic        reference_io_pin_oe_n,
   input wire logic        reference_io_pin_in,
   input wire logic        external_ref_sense,
   input wire logic        word_valid,
   input wire logic        word_ready,
   input wire logic        frame_start,
   input wire logic        fifo_ptr_reset,
   input wire logic        sync_event,
   input wire logic        frame_mode_sync,
   input wire logic        parity_error,
   input wire logic        parity_check_en,
   input wire logic        capture_overflow,
   input wire logic [15:0] reference_config_word,
   input wire ddrlc_word_t word_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Reference select, pin drive and two-flop sense
   property p_ref; $past(rst_n) && $stable(reference_config_word[0])
      |-> internal_ref_enable == !reference_config_word[0]; endproperty
   a_ref: assert property (p_ref) else $error("ref select");
   property p_oe; $past(rst_n) && $stable(reference_config_word[0])
      |-> reference_io_pin_oe_n == reference_config_word[0]; endproperty
   a_oe: assert property (p_oe) else $error("ref pin drive");
   property p_sense; $past(rst_n, 3)
      |-> external_ref_sense == $past(reference_io_pin_in, 2); endproperty
   a_sense: assert property (p_sense) else $error("ref sense");
   // Frame start goes to pointer reset or sync, never both
   property p_mode; frame_start |-> (frame_mode_sync ?
      sync_event && !fifo_ptr_reset : fifo_ptr_reset && !sync_event); endproperty
   a_mode: assert property (p_mode) else $error("frame routing");
   property p_cause; fifo_ptr_reset || sync_event |-> frame_start; endproperty
   a_cause: assert property (p_cause) else $error("stray frame pulse");
   // A stalled head word stays put, overflow only after a stalled head
   property p_hold; word_valid && !word_ready |=> word_valid && $stable(word_out);
   endproperty
   a_hold: assert property (p_hold) else $error("head word lost");
   property p_ovf; capture_overflow |-> $past(word_valid && !word_ready); endproperty
   a_ovf: assert property (p_ovf) else $error("overflow unfounded");
   property p_par; parity_error |-> parity_check_en; endproperty
   a_par: assert property (p_par) else $error("parity off");
endmodule // ddrlc_chk
bind ddrlc_capture ddrlc_chk chk (.*);
`default_nettype wire

/* File: tb/ddrlc_host_model.sv */
/* Behavioural host on the double-data-rate sample bus.
   Assumes the bench calls send once per link edge, then rest. */
`timescale 1ns/1ps
`default_nettype none
module ddrlc_host_model (
   output var logic        clk_o,
   output var logic        frame_o,
   output var logic [15:0] data_o
);
   // Link clock stands low between frames
   initial begin
      clk_o = 1'b0;
      frame_o = 1'b0;
      data_o = 16'h0000;
   end
   // Marker moves with the data, edge comes just after
   task automatic send(input logic [15:0] d, input logic f);
      data_o = d;
      frame_o = f;
      #5 clk_o = ~clk_o;
      #75;
   endtask
   // Released lines invert so stale values never match
   task automatic rest();
      data_o = ~data_o;
      frame_o = ~frame_o;
   endtask
endmodule // ddrlc_host_model
`default_nettype wire

/* File: tb/ddrlc_capture_tb.sv */
/* Self-checking bench of the capture front end.
   Assumes host model and checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module ddrlc_capture_tb
   import ddrlc_pkg::*;
;
   logic sys_clk = 1'b0, rst_n = 1'b0, mode = 1'b0, par_en = 1'b0, ready = 1'b1;
   logic ext = 1'b0, fe = 1'b0;
   logic [15:0] cfg = 16'h0000;
   logic lclk, lfrm, pin_in, pin_out, oe_n, iref, sense, vld, fs, pr, se, pe, ov;
   logic [15:0] ldat;
   ddrlc_word_t wout;
   ddrlc_word_t exp_q[$];
   int failures = 0, n_checks = 0, n_fs, n_pr, n_se, n_pe, n_ov;
   // System clock
   always #5 sys_clk = ~sys_clk;
   // Shared reference wire, device wins while oe_n is low
   assign pin_in = !oe_n ? pin_out : ext;
   ddrlc_host_model host (.clk_o(lclk), .frame_o(lfrm), .data_o(ldat));
   ddrlc_capture uut (.sys_clk(sys_clk), .rst_n(rst_n), .forwarded_sample_clock(lclk),
      .frame_marker_line(lfrm), .sample_data_line(ldat), .frame_mode_sync(mode),
      .parity_check_en(par_en), .reference_config_word(cfg), .reference_io_pin_in(pin_in),
      .reference_io_pin_out(pin_out), .reference_io_pin_oe_n(oe_n),
      .internal_ref_enable(iref), .external_ref_sense(sense), .word_valid(vld),
      .word_ready(ready), .word_out(wout), .fifo_ptr_reset(pr), .sync_event(se),
      .frame_start(fs), .parity_error(pe), .capture_overflow(ov));
   task automatic chk_b(string nm, logic e, logic g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_w(ddrlc_word_t e, ddrlc_word_t g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] word expected %h seen %h", e, g);
      end
   endtask
   task automatic chk_n(string nm, int e, int g);
      n_checks++;
      if (g != e) begin
         failures++;
         $display("[ERR] %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   // Pulse counters and pop-side word compare
   always @(posedge sys_clk) begin
      n_fs += (fs === 1'b1);
      n_pr += (pr === 1'b1);
      n_se += (se === 1'b1);
      n_pe += (pe === 1'b1);
      n_ov += (ov === 1'b1);
      if (vld === 1'b1 && ready === 1'b1) begin
         if (exp_q.size() == 0) chk_b("spare word", 1'b0, 1'b1);
         else chk_w(exp_q.pop_front(), wout);
      end
   end
   task automatic clr();
      {n_fs, n_pr, n_se, n_pe, n_ov} = '0;
      #3.3;
   endtask
   // Rise word first, edge flag flips per word
   task automatic snd(logic [15:0] d, logic f);
      exp_q.push_back({d, fe, f});
      fe = ~fe;
      host.send(d, f);
   endtask
   task automatic settle();
      host.rest();
      repeat (14) @(negedge sys_clk);
   endtask
   task automatic t_ref();
      chk_b("iref reset", 1'b1, iref);
      chk_b("vld reset", 1'b0, vld);
      cfg = 16'h0001;
      repeat (4) @(negedge sys_clk);
      chk_b("oe_n ext", 1'b1, oe_n);
      chk_b("sense lo", 1'b0, sense);
      ext = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk_b("sense hi", 1'b1, sense);
      cfg = 16'h0000;
      ext = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk_b("iref int", 1'b1, iref);
      chk_b("pin out", 1'b1, pin_in);
   endtask
   task automatic t_frame(logic m);
      mode = m;
      clr();
      snd(16'hA5C3, 1'b1);
      snd(16'h5A3C, 1'b0);
      snd(16'h0F0F, 1'b0);
      snd(16'hF0F0, 1'b1);
      settle();
      chk_n("frame_start", 1, n_fs);
      chk_n("ptr_reset", m ? 0 : 1, n_pr);
      chk_n("sync_event", m ? 1 : 0, n_se);
      chk_n("parity off", 0, n_pe);
      chk_n("words left", 0, exp_q.size());
   endtask
   task automatic t_par();
      par_en = 1'b1;
      clr();
      snd(16'h0001, 1'b0);
      snd(16'h0003, 1'b0);
      snd(16'h0000, 1'b1);
      snd(16'h0007, 1'b0);
      settle();
      chk_n("parity_error", 1, n_pe);
      par_en = 1'b0;
   endtask
   // Sink stalls, two words kept, two refused
   task automatic t_stall();
      ready = 1'b0;
      clr();
      for (int i = 1; i < 5; i++) snd(16'(16'h1111 * i), 1'b0);
      settle();
      chk_b("held valid", 1'b1, vld);
      chk_n("overflow", 2, n_ov);
      void'(exp_q.pop_back());
      void'(exp_q.pop_back());
      ready = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk_n("drained", 0, exp_q.size());
      chk_b("empty", 1'b0, vld);
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (12) @(negedge sys_clk);
      rst_n = 1'b1;
      @(negedge sys_clk);
      t_ref();
      t_frame(1'b0);
      t_frame(1'b1);
      t_par();
      t_stall();
      print_verdict();
   end
   // Watchdog, run needs about 2 us
   initial begin
      #20us;
      failures++;
      print_verdict();
   end
endmodule // ddrlc_capture_tb
`default_nettype wire
